// File: core/tec_map.svh
// register map, field positions, reset values and encodings for the timer
// assumes a 32-bit AXI4-Lite slave with word-aligned registers
`ifndef TEC_MAP_SVH
`define TEC_MAP_SVH

`define TEC_OFF_COUNT 4'h0
`define TEC_OFF_CTRL 4'h4
`define TEC_OFF_IRQ 4'h8
`define TEC_AXI_OKAY 2'h0
`define TEC_AXI_SLVERR 2'h2
`define TEC_CTRL_RST 8'h00
`define TEC_CNT_FULL 8'hFF
`define TEC_PRE_RST 8'h00
`define TEC_BIT_RUN 4
`define TEC_BIT_EDGE 3
`define TEC_BIT_MODE1 7
`define TEC_BIT_MODE0 6
`define TEC_BIT_IRQ_FLAG 0
`define TEC_BIT_IRQ_EN 1
`define TEC_PRE_W 3

`endif

// File: core/tec_pkg.sv
// types shared by the timer/event counter files
// assumes tec_map.svh sits on the include path
package tec_pkg;
  typedef enum logic [1:0] {
    TEC_MODE_IDLE,
    TEC_MODE_EVENT,
    TEC_MODE_TIMER,
    TEC_MODE_PULSE
  } tec_mode_t;
  typedef enum logic [1:0] {
    TEC_PW_ARMED,
    TEC_PW_COUNT,
    TEC_PW_DONE
  } tec_pw_t;
endpackage

// File: core/tec_prescaler.sv
// free-running prescaler that emits one tick per divided clock period
// assumes a single system clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module tec_prescaler #(
  parameter int STAGES = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // ratio select: divide by 2 to the power sel plus one
  input wire logic [2:0] sel,
  // one-cycle tick on the falling edge of the divided clock
  output logic tick
);
  logic [STAGES-1:0] div_q;
  logic [STAGES-1:0] div_d;
  logic tick_q;

  assign div_d = div_q + {{(STAGES-1){1'b0}}, 1'b1};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // high-to-low of the chosen stage is the counting edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q[sel] & ~div_d[sel];
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// File: core/tec_timer.sv
// 8-bit timer/event counter with preload, prescaler and AXI4-Lite access
// assumes pin input synchronous to aclk domain edge rate; one clock only
`include "tec_map.svh"
`timescale 1ns/10ps
`default_nettype none

module tec_timer
  import tec_pkg::*;
#(
  parameter int PRE_STAGES = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external event / pulse pin
  input wire logic timer_input_pin,
  // system side
  output logic timer_irq,
  output logic wake_request
);
  ////////////////////////////////////////////////////////////////////////
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_prev_q;
  logic pin_rise;
  logic pin_fall;
  logic pre_tick;
  logic [7:0] count_q;
  logic [7:0] preload_q;
  logic [7:0] ctrl_q;
  logic irq_flag_q;
  logic irq_en_q;
  logic irq_q;
  logic wake_q;
  tec_pw_t pw_q;
  tec_mode_t mode;
  logic run;
  logic edge_sel;
  logic start_edge;
  logic stop_edge;
  logic inc;
  logic ovf;
  logic aw_held_q;
  logic w_held_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic rd_go;
  logic wr_cnt;
  logic wr_ctrl;
  logic wr_irq;
  logic rd_cnt;
  logic hw_clr_run;

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser; edges are found from the second stage and its delayed copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= timer_input_pin;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end
  assign pin_rise = pin_s2_q & ~pin_prev_q;
  assign pin_fall = ~pin_s2_q & pin_prev_q;

  tec_prescaler #(
    .STAGES(PRE_STAGES)
  ) u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(ctrl_q[`TEC_PRE_W-1:0]),
    .tick(pre_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  assign mode = tec_mode_t'({ctrl_q[`TEC_BIT_MODE1], ctrl_q[`TEC_BIT_MODE0]});
  assign run = ctrl_q[`TEC_BIT_RUN];
  assign edge_sel = ctrl_q[`TEC_BIT_EDGE];
  // start edge leaves the idle level; stop edge returns to it
  assign start_edge = edge_sel ? pin_rise : pin_fall;
  assign stop_edge = edge_sel ? pin_fall : pin_rise;

  // counting clock source per mode; bus access to count inhibits it
  always_comb begin
    case (mode)
      TEC_MODE_TIMER: inc = pre_tick;
      // event counting is not gated by any power-down input
      TEC_MODE_EVENT: inc = edge_sel ? pin_fall : pin_rise;
      TEC_MODE_PULSE: inc = pre_tick & (pw_q == TEC_PW_COUNT);
      default: inc = 1'b0;
    endcase
    inc = inc & run & ~rd_cnt & ~wr_cnt;
  end
  assign ovf = inc & (count_q == `TEC_CNT_FULL);

  ////////////////////////////////////////////////////////////////////////
  // single-shot pulse measurement sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_q <= TEC_PW_ARMED;
    end else if (mode != TEC_MODE_PULSE || !run) begin
      pw_q <= TEC_PW_ARMED;
    end else begin
      case (pw_q)
        TEC_PW_ARMED: if (start_edge) pw_q <= TEC_PW_COUNT;
        TEC_PW_COUNT: if (stop_edge) pw_q <= TEC_PW_DONE;
        TEC_PW_DONE: pw_q <= TEC_PW_DONE;
        default: pw_q <= TEC_PW_ARMED;
      endcase
    end
  end
  assign hw_clr_run = (mode == TEC_MODE_PULSE) && run &&
                      (pw_q == TEC_PW_COUNT) && stop_edge;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite handshake: address and data taken in either order
  assign wr_go = aw_held_q & w_held_q & ~bvalid_q;
  assign rd_go = s_axi_arvalid & s_axi_arready;
  assign wr_cnt = wr_go & (awaddr_q == `TEC_OFF_COUNT) & wstrb_q[0];
  assign wr_ctrl = wr_go & (awaddr_q == `TEC_OFF_CTRL) & wstrb_q[0];
  assign wr_irq = wr_go & (awaddr_q == `TEC_OFF_IRQ) & wstrb_q[0];
  assign rd_cnt = rd_go & (s_axi_araddr == `TEC_OFF_COUNT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `TEC_AXI_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q == `TEC_OFF_COUNT || awaddr_q == `TEC_OFF_CTRL ||
                  awaddr_q == `TEC_OFF_IRQ) ? `TEC_AXI_OKAY : `TEC_AXI_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `TEC_AXI_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_q & ~s_axi_arready & s_axi_arvalid;
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= `TEC_AXI_OKAY;
        case (s_axi_araddr)
          `TEC_OFF_COUNT: rdata_q <= {24'h0, count_q};
          `TEC_OFF_CTRL: rdata_q <= {24'h0, ctrl_q};
          `TEC_OFF_IRQ: rdata_q <= {30'h0, irq_en_q, irq_flag_q};
          default: begin
            rdata_q <= 32'h0;
            rresp_q <= `TEC_AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  ////////////////////////////////////////////////////////////////////////
  // control register: device may only clear run in pulse mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `TEC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata_q[7:0];
    end else if (hw_clr_run) begin
      ctrl_q[`TEC_BIT_RUN] <= 1'b0;
    end
  end

  // preload and counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preload_q <= `TEC_PRE_RST;
    end else if (wr_cnt) begin
      preload_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= `TEC_PRE_RST;
    end else if (wr_cnt && !run) begin
      count_q <= wdata_q[7:0];
    end else if (ovf) begin
      count_q <= preload_q;
    end else if (inc) begin
      count_q <= count_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overflow flag: set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag_q <= 1'b0;
      irq_en_q <= 1'b0;
    end else begin
      if (ovf) begin
        irq_flag_q <= 1'b1;
      end else if (wr_irq) begin
        irq_flag_q <= wdata_q[`TEC_BIT_IRQ_FLAG];
      end
      if (wr_irq) begin
        irq_en_q <= wdata_q[`TEC_BIT_IRQ_EN];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= irq_flag_q & irq_en_q;
      wake_q <= ovf;
    end
  end
  assign timer_irq = irq_q;
  assign wake_request = wake_q;

  ////////////////////////////////////////////////////////////////////////
  a_ovf_reload: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ovf && !(wr_cnt && !run) |=> count_q == $past(preload_q))
    else $error("counter did not reload on overflow");
  a_ovf_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ovf |=> irq_flag_q)
    else $error("overflow did not set flag");
  a_wake_pulse: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ovf |=> wake_request)
    else $error("overflow gave no wake-up");
  a_irq_gated: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timer_irq |-> $past(irq_en_q) && $past(irq_flag_q))
    else $error("interrupt without enable");
  a_stop_load: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_cnt && !run |=> count_q == $past(wdata_q[7:0]))
    else $error("stopped write did not load counter");
  a_run_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    mode != TEC_MODE_PULSE && !wr_ctrl && run |=> run)
    else $error("run cleared by device outside pulse mode");
  a_no_count_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !run && !wr_cnt |=> $stable(count_q))
    else $error("counter moved while stopped");
  a_inhibit_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_cnt && !wr_cnt && count_q != `TEC_CNT_FULL |=> $stable(count_q))
    else $error("counter moved during read");
  a_event_edge: assert property (
    @(posedge aclk) disable iff (!aresetn)
    mode == TEC_MODE_EVENT && run && !edge_sel && pin_rise && !rd_cnt &&
    !wr_cnt && count_q != `TEC_CNT_FULL |=> count_q == $past(count_q) + 8'h01)
    else $error("event edge not counted");
  sequence s_pulse_end; !run ##1 pw_q == TEC_PW_ARMED; endsequence
  a_pulse_stop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    hw_clr_run && !wr_ctrl |=> s_pulse_end)
    else $error("pulse end did not clear run");
endmodule
`default_nettype wire

// File: dv/tec_pin_source.sv
// pin source model: an external pulse or event source on the timer pin
// assumes the bench clock; every level change follows a rising edge
`timescale 1ns/10ps
`default_nettype none
module tec_pin_source (
  // bench clock
  input wire logic aclk,
  // driven pin
  output logic pin
);
  initial pin = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // push-pull source, so the line always shows a real level
  // hold of two cycles or more keeps each level visible to the synchroniser
  task automatic set_level(input logic lvl, input int hold);
    @(posedge aclk);
    pin <= lvl;
    repeat (hold) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// File: dv/test_tec_timer.sv
// self-checking bench for the timer/event counter, with a reference model
// assumes the core files and tec_pin_source.sv are compiled first
`include "tec_map.svh"
`timescale 1ns/10ps
`default_nettype none
module test_tec_timer;
  import tec_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic timer_input_pin, timer_irq, wake_request;
  logic [31:0] rd;
  int num_errors = 0, total_checks = 0, seed = 69, wake_n = 0;
  int m_pre, m_cnt, m_flag, m_ovf;
  ////////////////////////////////////////////////////////////////////////////
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) if (wake_request === 1'b1) wake_n++;
  tec_timer #(.PRE_STAGES(8)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer_input_pin, .timer_irq, .wake_request);
  tec_pin_source PIN (.aclk, .pin(timer_input_pin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bound(input int i);
    if (i >= 100) begin
      num_errors++;
      end_sim();
    end
  endtask
  // bready and rready stay high, so every answer is taken when it shows
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int i;
    logic aw;
    logic w;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    for (i = 0; i < 100 && !(aw && w); i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    bound(i);
    for (i = 0; i < 100 && s_axi_bvalid !== 1'b1; i++) @(posedge aclk);
    bound(i);
    rs = s_axi_bresp;
  endtask
  task automatic rdr(input logic [3:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 100 && s_axi_arready !== 1'b1; i++) @(posedge aclk);
    bound(i);
    s_axi_arvalid <= 1'b0;
    for (i = 0; i < 100 && s_axi_rvalid !== 1'b1; i++) @(posedge aclk);
    bound(i);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // reference counter: one step per counted event
  task automatic m_tick();
    if (m_cnt == 255) begin
      m_cnt = m_pre;
      m_flag = 1;
      m_ovf++;
    end else begin
      m_cnt++;
    end
  endtask
  task automatic pulse(input logic idle, input int len);
    PIN.set_level(!idle, len);
    PIN.set_level(idle, len);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int e, k, n, c;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 3; k++) begin
      rdr(4'(k * 4));
      chk(rd, 32'h0);
    end
    rdr(4'hC);
    chk(rs, `TEC_AXI_SLVERR);
    wr(4'hC, 8'hFF);
    chk(rs, `TEC_AXI_SLVERR);
    // edge select: only the chosen pin edge advances the count
    for (e = 0; e < 2; e++) begin
      wr(`TEC_OFF_CTRL, {4'h4, e[0], 3'h0});
      wr(`TEC_OFF_COUNT, 8'h20);
      wr(`TEC_OFF_CTRL, {4'h5, e[0], 3'h0});
      PIN.set_level(1'b1, 8);
      rdr(`TEC_OFF_COUNT);
      chk(rd, 32'h20 + 32'(e == 0));
      PIN.set_level(1'b0, 8);
      rdr(`TEC_OFF_COUNT);
      chk(rd, 32'h21);
    end
    // overflow, reload, flag and wake-up against the model
    wr(`TEC_OFF_CTRL, 8'h40);
    wr(`TEC_OFF_COUNT, 8'hFD);
    m_pre = 'hFD;
    m_cnt = 'hFD;
    m_flag = 0;
    m_ovf = wake_n;
    wr(`TEC_OFF_CTRL, 8'h50);
    for (k = 0; k < 4; k++) begin
      pulse(1'b0, 2 + ($random(seed) & 7));
      m_tick();
    end
    repeat (6) @(posedge aclk);
    rdr(`TEC_OFF_COUNT);
    chk(rd, m_cnt);
    rdr(`TEC_OFF_IRQ);
    chk(rd, m_flag);
    chk(timer_irq, 1'b0);
    chk(wake_n, m_ovf);
    wr(`TEC_OFF_COUNT, 8'h10);
    m_pre = 'h10;
    rdr(`TEC_OFF_COUNT);
    chk(rd, m_cnt);
    n = 256 - m_cnt;
    for (k = 0; k < n; k++) begin
      pulse(1'b0, 2 + ($random(seed) & 7));
      m_tick();
    end
    repeat (6) @(posedge aclk);
    rdr(`TEC_OFF_COUNT);
    chk(rd, m_cnt);
    chk(wake_n, m_ovf);
    rdr(`TEC_OFF_CTRL);
    chk(rd, 32'h50);
    wr(`TEC_OFF_IRQ, 8'h03);
    repeat (2) @(posedge aclk);
    chk(timer_irq, 1'b1);
    wr(`TEC_OFF_IRQ, 8'h02);
    rdr(`TEC_OFF_IRQ);
    chk(rd, 32'h2);
    chk(timer_irq, 1'b0);
    // interval timer: rate follows the prescale field, with slack for phase
    for (k = 0; k < 4; k++) begin
      wr(`TEC_OFF_CTRL, 8'h80 | 8'(k));
      wr(`TEC_OFF_COUNT, 8'h00);
      wr(`TEC_OFF_CTRL, 8'h90 | 8'(k));
      rdr(`TEC_OFF_COUNT);
      c = int'(rd);
      repeat (64) @(posedge aclk);
      rdr(`TEC_OFF_COUNT);
      n = int'((rd - c) & 255);
      c = 66 >> (k + 1);
      chk(n > c - 3 && n < c + 3, 1'b1);
    end
    // mode bits both clear: the counter stands whatever the pin does
    wr(`TEC_OFF_CTRL, 8'h10);
    rdr(`TEC_OFF_COUNT);
    c = int'(rd);
    pulse(1'b0, 6);
    repeat (4) @(posedge aclk);
    rdr(`TEC_OFF_COUNT);
    chk(rd, c);
    // pulse width: a level alone starts nothing; one shot, then ignored
    for (e = 0; e < 2; e++) begin
      PIN.set_level(!e[0], 8);
      wr(`TEC_OFF_CTRL, {4'hC, e[0], 3'h0});
      wr(`TEC_OFF_COUNT, 8'h00);
      PIN.set_level(e[0], 4);
      wr(`TEC_OFF_CTRL, {4'hD, e[0], 3'h0});
      PIN.set_level(!e[0], 20);
      rdr(`TEC_OFF_COUNT);
      chk(rd, 32'h0);
      pulse(!e[0], 40);
      rdr(`TEC_OFF_CTRL);
      chk(rd, {4'hC, e[0], 3'h0});
      rdr(`TEC_OFF_COUNT);
      c = int'(rd);
      chk(c > 16 && c < 24, 1'b1);
      pulse(!e[0], 20);
      rdr(`TEC_OFF_COUNT);
      chk(rd, c);
    end
    end_sim();
  end
endmodule
`default_nettype wire
